// ===== hw/port_cond_pkg.sv
// Shared constants and types for the port channel conditioning block
package port_cond_pkg;
    // ****************************************
    // Geometry
    // ****************************************
    localparam int NUM_PORTS = 8;
    localparam int NUM_CH    = 16;

    // ****************************************
    // Parameter object indices
    // ****************************************
    localparam logic [15:0] IDX_CHB_MODE  = 16'h2383;
    localparam logic [15:0] IDX_IN_LOGIC  = 16'h2384;
    localparam logic [15:0] IDX_FILTER    = 16'h2385;
    localparam logic [15:0] IDX_RESTART   = 16'h2386;
    localparam logic [15:0] IDX_LATCH_EN  = 16'h2389;
    localparam logic [7:0]  SUB_COUNT_CH  = 8'h10;
    localparam logic [7:0]  SUB_COUNT_PRT = 8'h08;

    // ****************************************
    // Encodings and reset values
    // ****************************************
    localparam logic [7:0] MODE_INPUT    = 8'h01;
    localparam logic [7:0] MODE_OUTPUT   = 8'h02;
    localparam logic [7:0] BOOL_MAX      = 8'h01;
    localparam logic [7:0] RST_FILTER    = 8'h00;
    localparam logic [7:0] RST_RESTART   = 8'h00;
    localparam logic [7:0] RST_CHB_MODE  = MODE_INPUT;
    localparam logic       RST_LATCH_EN  = 1'b0;
    localparam logic       RST_POLARITY  = 1'b0;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS      = 10;
    localparam int FILTER_STEP_NS     = 100000;
    localparam int FILTER_STEP_CYCLES = (FILTER_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESTART_UNIT_MS    = 1;
    localparam int RESTART_UNIT_STEPS = RESTART_UNIT_MS * 1000000 / FILTER_STEP_NS;

    typedef enum {ST_RUN, ST_WAIT} restart_state_t;
endpackage : port_cond_pkg

// ===== hw/input_filter.sv
// Input synchroniser and stability filter for one channel
`timescale 1ns/1ps
module input_filter
    import port_cond_pkg::*;
(
    input  wire logic       i_ref_clk,  // System clock
    input  wire logic       i_srst,     // Sync reset
    input  wire logic       i_tick,     // 0.1 ms step pulse
    input  wire logic       i_raw,      // Pin level, async
    input  wire logic [7:0] i_setting,  // Filter length in steps
    output logic            o_level     // Accepted level
);
    logic       sync1;
    logic       sync2;
    logic       sync3;
    logic [7:0] stable_cnt;
    logic       differs;

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= i_raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Only a level on which two stages agree may count
    assign differs = (sync2 == sync3) && (sync3 != o_level);

    always_ff @(posedge i_ref_clk) begin
        if (i_srst || !differs) begin
            stable_cnt <= 8'h00;
        end else if (i_tick && stable_cnt != 8'hFF) begin
            stable_cnt <= stable_cnt + 8'h01;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_level <= 1'b0;
        end else if (differs && stable_cnt >= i_setting) begin
            o_level <= sync3;
        end
    end
endmodule : input_filter

// ===== hw/restart_timer.sv
// Fault backoff and restart of one digital output channel
`timescale 1ns/1ps
module restart_timer
    import port_cond_pkg::*;
(
    input  wire logic       i_ref_clk,   // System clock
    input  wire logic       i_srst,      // Sync reset
    input  wire logic       i_tick_ms,   // 1 ms pulse
    input  wire logic       i_is_output, // Channel in output mode
    input  wire logic       i_cmd,       // Requested output level
    input  wire logic       i_fault,     // Driver fault flag
    input  wire logic [7:0] i_timeout,   // Restart delay in ms
    output logic            o_drive,     // Output switch
    output logic            o_waiting    // Held off after fault
);
    restart_state_t state;
    restart_state_t next_state;
    logic [7:0]     wait_ms;

    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (i_is_output && o_drive && i_fault) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Ms ticks are free running: wait is timeout-1 to timeout ms
                if (!i_is_output || wait_ms >= i_timeout) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst || state != ST_WAIT) begin
            wait_ms <= 8'h00;
        end else if (i_tick_ms && wait_ms != 8'hFF) begin
            wait_ms <= wait_ms + 8'h01;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_drive   <= 1'b0;
            o_waiting <= 1'b0;
        end else begin
            o_drive   <= (next_state == ST_RUN) && i_is_output && i_cmd;
            o_waiting <= (next_state == ST_WAIT);
        end
    end
endmodule : restart_timer

// ===== hw/port_channel_input_latch_filter.sv
// Input filter, output restart and input latch for sixteen port channels
`timescale 1ns/1ps

// Notes on behaviour
// - Filter setting counts 0.1 ms steps.
// - Sixteen filter bytes, used by inputs only.
// - Sixteen restart timeouts in milliseconds.
// - Restart timeout used only for outputs.
// - Per-channel latch enable, one means on.
// - Input edge drives latch set.
// - Master control bit drives latch reset.
// - Latch output replaces input status bit.
// - Hold, set, reset dominant truth table.
// - Rising logical edge sets latch.
// - Set latch holds until master clears.
// - Control bit high forces latch low.
// - Inverted polarity feeds inverted level.
// - Enabling while input high sets latch.
// - Latch only in digital input mode.
// - Polarity setting: zero open, one closed.
// - Channel B mode: one in, two out.
module port_channel_input_latch_filter
    import port_cond_pkg::*;
#(
    parameter int TICK_CYCLES = FILTER_STEP_CYCLES  // Cycles per 0.1 ms
)(
    input  wire logic        i_ref_clk,        // 100 MHz clock
    input  wire logic        i_srst,           // Sync reset
    input  wire logic        i_sdo_req,        // Parameter access pulse
    input  wire logic        i_sdo_write,      // 1 write, 0 read
    input  wire logic [15:0] i_sdo_index,      // Object index
    input  wire logic [7:0]  i_sdo_sub,        // Subindex
    input  wire logic [7:0]  i_sdo_wdata,      // Write value
    output logic             o_sdo_ack,        // Access done pulse
    output logic             o_sdo_err,        // Access refused
    output logic [7:0]       o_sdo_rdata,      // Read value
    input  wire logic [15:0] i_din_raw,        // Channel pins, async
    input  wire logic [7:0]  i_cha_out_mode,   // Channel A is output
    input  wire logic [15:0] i_latch_clr,      // Master latch reset bits
    input  wire logic [15:0] i_dout_cmd,       // Master output levels
    input  wire logic [15:0] i_dout_fault,     // Output driver faults
    output logic [15:0]      o_din_status,     // Input status bits
    output logic [15:0]      o_dout_drive,     // Output switches
    output logic [15:0]      o_restart_wait    // Output held after fault
);
    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0]  filt_set [NUM_CH];
    logic [7:0]  restart_set [NUM_CH];
    logic [7:0]  chb_mode [NUM_PORTS];
    logic [15:0] latch_en;
    logic [15:0] polarity;

    logic [15:0] step_cnt;
    logic        step_tick;
    logic [3:0]  ms_div;
    logic        ms_tick;

    logic [15:0] is_input;
    logic [15:0] is_output;
    logic [15:0] filt_level;
    logic [15:0] logical;
    logic [15:0] logical_q;
    logic [15:0] latch_act;
    logic [15:0] act_q;
    logic [15:0] set_ev;
    logic [15:0] latch_q;
    logic [15:0] next_latch;

    logic        sub_zero;
    logic        hit_ch;
    logic        hit_port;
    logic [3:0]  ch_idx;
    logic [2:0]  port_idx;
    logic [7:0]  rd_val;
    logic        bad;
    logic        wr_ok;

    // ****************************************
    // Timebase
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            step_cnt  <= 16'h0000;
            step_tick <= 1'b0;
        end else if (step_cnt == 16'(TICK_CYCLES - 1)) begin
            step_cnt  <= 16'h0000;
            step_tick <= 1'b1;
        end else begin
            step_cnt  <= step_cnt + 16'h0001;
            step_tick <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ms_div  <= 4'h0;
            ms_tick <= 1'b0;
        end else if (step_tick && ms_div == 4'(RESTART_UNIT_STEPS - 1)) begin
            ms_div  <= 4'h0;
            ms_tick <= 1'b1;
        end else begin
            ms_div  <= step_tick ? ms_div + 4'h1 : ms_div;
            ms_tick <= 1'b0;
        end
    end

    // ****************************************
    // Parameter access decode
    // ****************************************
    assign sub_zero = (i_sdo_sub == 8'h00);
    assign hit_ch   = !sub_zero && (i_sdo_sub <= SUB_COUNT_CH);
    assign hit_port = !sub_zero && (i_sdo_sub <= SUB_COUNT_PRT);
    assign ch_idx   = 4'(i_sdo_sub - 8'h01);
    assign port_idx = 3'(i_sdo_sub - 8'h01);

    always_comb begin
        rd_val = 8'h00;
        bad    = 1'b0;
        if (i_sdo_index == IDX_FILTER) begin
            if (sub_zero) begin
                rd_val = SUB_COUNT_CH;
            end else if (hit_ch) begin
                rd_val = filt_set[ch_idx];
            end else begin
                bad = 1'b1;
            end
        end else if (i_sdo_index == IDX_RESTART) begin
            if (sub_zero) begin
                rd_val = SUB_COUNT_CH;
            end else if (hit_ch) begin
                rd_val = restart_set[ch_idx];
            end else begin
                bad = 1'b1;
            end
        end else if (i_sdo_index == IDX_LATCH_EN) begin
            if (sub_zero) begin
                rd_val = SUB_COUNT_CH;
            end else if (hit_ch) begin
                rd_val = {7'h00, latch_en[ch_idx]};
            end else begin
                bad = 1'b1;
            end
            if (i_sdo_write && i_sdo_wdata > BOOL_MAX) begin
                bad = 1'b1;
            end
        end else if (i_sdo_index == IDX_IN_LOGIC) begin
            if (sub_zero) begin
                rd_val = SUB_COUNT_CH;
            end else if (hit_ch) begin
                rd_val = {7'h00, polarity[ch_idx]};
            end else begin
                bad = 1'b1;
            end
            if (i_sdo_write && i_sdo_wdata > BOOL_MAX) begin
                bad = 1'b1;
            end
        end else if (i_sdo_index == IDX_CHB_MODE) begin
            if (sub_zero) begin
                rd_val = SUB_COUNT_PRT;
            end else if (hit_port) begin
                rd_val = chb_mode[port_idx];
            end else begin
                bad = 1'b1;
            end
            // Reserved modes are refused, not stored
            if (i_sdo_write && i_sdo_wdata != MODE_INPUT && i_sdo_wdata != MODE_OUTPUT) begin
                bad = 1'b1;
            end
        end else begin
            bad = 1'b1;
        end
        if (i_sdo_write && sub_zero) begin
            bad = 1'b1;
        end
    end

    assign wr_ok = i_sdo_req && i_sdo_write && !bad;

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_sdo_ack   <= 1'b0;
            o_sdo_err   <= 1'b0;
            o_sdo_rdata <= 8'h00;
        end else begin
            o_sdo_ack   <= i_sdo_req;
            o_sdo_err   <= i_sdo_req && bad;
            o_sdo_rdata <= (i_sdo_req && !i_sdo_write && !bad) ? rd_val : 8'h00;
        end
    end

    // ****************************************
    // Parameter storage
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                filt_set[i] <= RST_FILTER;
            end
        end else if (wr_ok && i_sdo_index == IDX_FILTER) begin
            filt_set[ch_idx] <= i_sdo_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                restart_set[i] <= RST_RESTART;
            end
        end else if (wr_ok && i_sdo_index == IDX_RESTART) begin
            restart_set[ch_idx] <= i_sdo_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                chb_mode[i] <= RST_CHB_MODE;
            end
        end else if (wr_ok && i_sdo_index == IDX_CHB_MODE) begin
            chb_mode[port_idx] <= i_sdo_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            latch_en <= {NUM_CH{RST_LATCH_EN}};
        end else if (wr_ok && i_sdo_index == IDX_LATCH_EN) begin
            latch_en[ch_idx] <= i_sdo_wdata[0];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            polarity <= {NUM_CH{RST_POLARITY}};
        end else if (wr_ok && i_sdo_index == IDX_IN_LOGIC) begin
            polarity[ch_idx] <= i_sdo_wdata[0];
        end
    end

    // ****************************************
    // Per-channel paths
    // ****************************************
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        localparam int PRT = ch / 2;

        // Channel A direction comes from outside; channel B from its mode byte
        assign is_input[ch]  = (ch % 2 == 0) ? !i_cha_out_mode[PRT] : (chb_mode[PRT] == MODE_INPUT);
        assign is_output[ch] = (ch % 2 == 0) ? i_cha_out_mode[PRT] : (chb_mode[PRT] == MODE_OUTPUT);

        input_filter u_filter (
            .i_ref_clk (i_ref_clk),
            .i_srst    (i_srst),
            .i_tick    (step_tick),
            .i_raw     (i_din_raw[ch]),
            .i_setting (is_input[ch] ? filt_set[ch] : 8'h00),
            .o_level   (filt_level[ch])
        );

        assign logical[ch]   = filt_level[ch] ^ polarity[ch];
        assign latch_act[ch] = latch_en[ch] && is_input[ch];
        // Also fires when the latch turns on over a high input
        assign set_ev[ch]    = latch_act[ch] && logical[ch] && !(logical_q[ch] && act_q[ch]);

        restart_timer u_restart (
            .i_ref_clk   (i_ref_clk),
            .i_srst      (i_srst),
            .i_tick_ms   (ms_tick),
            .i_is_output (is_output[ch]),
            .i_cmd       (i_dout_cmd[ch]),
            .i_fault     (i_dout_fault[ch]),
            .i_timeout   (restart_set[ch]),
            .o_drive     (o_dout_drive[ch]),
            .o_waiting   (o_restart_wait[ch])
        );
    end

    // ****************************************
    // Input latch
    // ****************************************
    // Reset dominates; a disabled latch is kept clear
    assign next_latch = latch_act & ~i_latch_clr & (set_ev | latch_q);

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            latch_q   <= 16'h0000;
            logical_q <= 16'h0000;
            act_q     <= 16'h0000;
        end else begin
            latch_q   <= next_latch;
            logical_q <= logical;
            act_q     <= latch_act;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_din_status <= 16'h0000;
        end else begin
            o_din_status <= (latch_act & next_latch) | (~latch_act & is_input & logical);
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    a_reset_dominates: assert property (
        1 |=> ((latch_q & $past(i_latch_clr)) == 16'h0000))
        else $error("latch not cleared by control bit");

    a_edge_sets: assert property (
        1 |=> ((latch_q & $past(set_ev & ~i_latch_clr)) == $past(set_ev & ~i_latch_clr)))
        else $error("latch not set by edge");

    a_latch_holds: assert property (
        1 |=> (($past(latch_q & ~i_latch_clr & latch_act) & ~latch_q) == 16'h0000))
        else $error("latch dropped without clear");

    a_enable_high: assert property (
        1 |=> ((latch_q & $past(latch_act & ~act_q & logical & ~i_latch_clr))
               == $past(latch_act & ~act_q & logical & ~i_latch_clr)))
        else $error("enable over high input not latched");

    a_input_only: assert property (
        1 |=> ((latch_q & ~$past(is_input)) == 16'h0000))
        else $error("latch active outside input mode");

    a_status_source: assert property (
        1 |=> (o_din_status == (($past(latch_act) & latch_q) | ($past(~latch_act & is_input & logical)))))
        else $error("status bit from wrong source");

    a_wait_no_drive: assert property (
        (o_restart_wait & o_dout_drive) == 16'h0000)
        else $error("output driven during restart wait");

    a_filter_store: assert property (
        (wr_ok && i_sdo_index == IDX_FILTER) |=> (filt_set[$past(ch_idx)] == $past(i_sdo_wdata)))
        else $error("filter setting not stored");

    a_sdo_answer: assert property (
        i_sdo_req |=> o_sdo_ack ##1 !o_sdo_ack || $past(i_sdo_req))
        else $error("access not answered once");

    a_step_period: assert property (
        step_tick |=> !step_tick)
        else $error("step tick too fast");

    c_latch_set: cover property (set_ev[1] ##[1:20] i_latch_clr[1]);
    c_restart: cover property ($rose(o_restart_wait[0]) ##[1:1000] $fell(o_restart_wait[0]));
    c_sdo_write: cover property (wr_ok && i_sdo_index == IDX_LATCH_EN);
    c_sdo_error: cover property (o_sdo_err);
endmodule : port_channel_input_latch_filter

// ===== bench/plc_master_model.sv
// Fieldbus master model: latch clear bits and output levels
`timescale 1ns/1ps
module plc_master_model (
    input  wire logic        i_ref_clk,   // System clock
    output logic      [15:0] o_latch_clr, // Latch reset bits
    output logic      [15:0] o_dout_cmd   // Output levels
);
    initial begin
        o_latch_clr = 16'h0000;
        o_dout_cmd  = 16'h0000;
    end
    // Pulse before use, so the latch starts cleared
    task automatic pulse_clear(input logic [15:0] mask, input int len);
        @(posedge i_ref_clk);
        #1 o_latch_clr = o_latch_clr | mask;
        repeat (len) @(posedge i_ref_clk);
        #1 o_latch_clr = o_latch_clr & ~mask;
    endtask : pulse_clear
    task automatic set_clr(input logic [15:0] v);
        o_latch_clr = v;
    endtask : set_clr
    task automatic set_cmd(input logic [15:0] v);
        o_dout_cmd = v;
    endtask : set_cmd
endmodule : plc_master_model

// ===== bench/tb_port_channel_input_latch_filter.sv
// Self-checking bench for the port channel conditioning block
`timescale 1ns/1ps
module tb_port_channel_input_latch_filter;
    import port_cond_pkg::*;
    localparam int T = 4;
    logic        i_ref_clk = 1'b0;
    logic        i_srst    = 1'b1;
    logic        i_sdo_req = 1'b0;
    logic        i_sdo_write = 1'b0;
    logic [15:0] i_sdo_index = 16'h0000;
    logic [7:0]  i_sdo_sub = 8'h00;
    logic [7:0]  i_sdo_wdata = 8'h00;
    logic        o_sdo_ack;
    logic        o_sdo_err;
    logic [7:0]  o_sdo_rdata;
    logic [15:0] i_din_raw = 16'h0000;
    logic [7:0]  i_cha_out_mode = 8'h00;
    logic [15:0] latch_clr;
    logic [15:0] dout_cmd;
    logic [15:0] i_dout_fault = 16'h0000;
    logic [15:0] o_din_status;
    logic [15:0] o_dout_drive;
    logic [15:0] o_restart_wait;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          seed = 32'hC55F6BF0;
    logic [7:0]  mdl [int];

    always #5 i_ref_clk = ~i_ref_clk;

    port_channel_input_latch_filter #(.TICK_CYCLES(T)) u_dut (
        .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_sdo_req(i_sdo_req),
        .i_sdo_write(i_sdo_write), .i_sdo_index(i_sdo_index), .i_sdo_sub(i_sdo_sub),
        .i_sdo_wdata(i_sdo_wdata), .o_sdo_ack(o_sdo_ack), .o_sdo_err(o_sdo_err),
        .o_sdo_rdata(o_sdo_rdata), .i_din_raw(i_din_raw), .i_cha_out_mode(i_cha_out_mode),
        .i_latch_clr(latch_clr), .i_dout_cmd(dout_cmd), .i_dout_fault(i_dout_fault),
        .o_din_status(o_din_status), .o_dout_drive(o_dout_drive), .o_restart_wait(o_restart_wait));
    plc_master_model u_plc (.i_ref_clk(i_ref_clk), .o_latch_clr(latch_clr), .o_dout_cmd(dout_cmd));

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : tick

    // Model of refusal: unknown object, sub range, bad values
    function automatic logic bad(logic w, logic [15:0] ix, logic [7:0] sb, logic [7:0] wd);
        if (!(ix inside {IDX_CHB_MODE, IDX_IN_LOGIC, IDX_FILTER, IDX_RESTART, IDX_LATCH_EN})) return 1'b1;
        if (sb > ((ix == IDX_CHB_MODE) ? 8 : 16)) return 1'b1;
        if (w && sb == 8'h00) return 1'b1;
        if (w && ix inside {IDX_IN_LOGIC, IDX_LATCH_EN} && wd > 8'h01) return 1'b1;
        if (w && ix == IDX_CHB_MODE && !(wd inside {MODE_INPUT, MODE_OUTPUT})) return 1'b1;
        return 1'b0;
    endfunction : bad

    // One access, compared with the model, which it then updates
    task automatic acc(input logic w, input logic [15:0] ix, input logic [7:0] sb, input logic [7:0] wd);
        logic       e;
        logic [7:0] ev;
        int         k;
        e  = bad(w, ix, sb, wd);
        ev = (w || e) ? 8'h00 : (sb == 8'h00) ? ((ix == IDX_CHB_MODE) ? SUB_COUNT_PRT : SUB_COUNT_CH)
             : mdl[int'({ix, sb})];
        {i_sdo_req, i_sdo_write, i_sdo_index, i_sdo_sub, i_sdo_wdata} = {1'b1, w, ix, sb, wd};
        tick(1);
        i_sdo_req = 1'b0;
        k = 0;
        while (o_sdo_ack !== 1'b1 && k < 4) begin
            tick(1);
            k++;
        end
        if (k == 4) begin
            n_fail++;
            end_of_test;
        end
        chk("sdo_err", o_sdo_err, e);
        chk("sdo_rdata", o_sdo_rdata, ev);
        if (w && !e) mdl[int'({ix, sb})] = wd;
        // Idle edge, so the next request never re-raises req in this step
        tick(1);
    endtask : acc

    initial begin
        #100000;
        n_fail++;
        end_of_test;
    end

    initial begin
        for (int s = 1; s <= 16; s++) begin
            mdl[int'({IDX_IN_LOGIC, 8'(s)})] = 8'h00;
            mdl[int'({IDX_FILTER, 8'(s)})]   = RST_FILTER;
            mdl[int'({IDX_RESTART, 8'(s)})]  = RST_RESTART;
            mdl[int'({IDX_LATCH_EN, 8'(s)})] = 8'h00;
            if (s <= 8) mdl[int'({IDX_CHB_MODE, 8'(s)})] = RST_CHB_MODE;
        end
        tick(12);
        i_srst = 1'b0;
        // ****************************************
        // Reset values, counts, refusals
        // ****************************************
        for (int i = 0; i < 5; i++) begin
            acc(1'b0, 16'h2383 + 16'(i == 4 ? 6 : i), 8'h00, 8'h00);
            acc(1'b0, 16'h2383 + 16'(i == 4 ? 6 : i), 8'h01, 8'h00);
        end
        acc(1'b0, 16'h2387, 8'h01, 8'h00);
        acc(1'b0, IDX_FILTER, 8'h11, 8'h00);
        acc(1'b1, IDX_LATCH_EN, 8'h01, 8'h02);
        acc(1'b1, IDX_CHB_MODE, 8'h09, 8'h01);
        for (int v = 0; v < 4; v++) acc(1'b1, IDX_CHB_MODE, 8'h02, 8'(v));
        acc(1'b1, IDX_FILTER, 8'h00, 8'h05);
        // ****************************************
        // Filter: glitch rejected, steady level taken
        // ****************************************
        acc(1'b1, IDX_FILTER, 8'h01, 8'h03);
        i_din_raw[0] = 1'b1;
        tick(2);
        i_din_raw[0] = 1'b0;
        tick(10);
        chk("glitch", o_din_status[0], 1'b0);
        i_din_raw[0] = 1'b1;
        tick(10);
        chk("early", o_din_status[0], 1'b0);
        tick(20);
        chk("settled", o_din_status[0], 1'b1);
        // ****************************************
        // Latch on port 1 channel B
        // ****************************************
        acc(1'b1, IDX_LATCH_EN, 8'h02, 8'h01);
        u_plc.pulse_clear(16'h0002, 2);
        tick(8);
        chk("latch_clr0", o_din_status[1], 1'b0);
        i_din_raw[1] = 1'b1;
        tick(8);
        chk("latch_set", o_din_status[1], 1'b1);
        i_din_raw[1] = 1'b0;
        tick(8);
        chk("latch_hold", o_din_status[1], 1'b1);
        u_plc.set_clr(16'h0002);
        i_din_raw[1] = 1'b1;
        tick(8);
        chk("latch_rst", o_din_status[1], 1'b0);
        u_plc.set_clr(16'h0000);
        tick(8);
        chk("no_edge", o_din_status[1], 1'b0);
        acc(1'b1, IDX_LATCH_EN, 8'h02, 8'h00);
        tick(8);
        chk("plain_in", o_din_status[1], 1'b1);
        acc(1'b1, IDX_LATCH_EN, 8'h02, 8'h01);
        tick(8);
        chk("en_high", o_din_status[1], 1'b1);
        acc(1'b1, IDX_IN_LOGIC, 8'h02, 8'h01);
        u_plc.pulse_clear(16'h0002, 1);
        tick(8);
        chk("inv_clr", o_din_status[1], 1'b0);
        i_din_raw[1] = 1'b0;
        tick(8);
        chk("inv_fall", o_din_status[1], 1'b1);
        acc(1'b1, IDX_CHB_MODE, 8'h01, MODE_OUTPUT);
        tick(8);
        chk("out_mode", o_din_status[1], 1'b0);
        // ****************************************
        // Output restart after a fault
        // ****************************************
        i_cha_out_mode = 8'h01;
        u_plc.set_cmd(16'h0005);
        acc(1'b1, IDX_RESTART, 8'h01, 8'h02);
        tick(8);
        chk("drive_on", o_dout_drive[0], 1'b1);
        chk("in_drive", o_dout_drive[2], 1'b0);
        chk("out_stat", o_din_status[0], 1'b0);
        i_dout_fault[0] = 1'b1;
        tick(3);
        i_dout_fault[0] = 1'b0;
        chk("fault_off", {o_dout_drive[0], o_restart_wait[0]}, 2'b01);
        tick(27);
        chk("still_wait", o_restart_wait[0], 1'b1);
        tick(60);
        chk("restarted", {o_dout_drive[0], o_restart_wait[0]}, 2'b10);
        // ****************************************
        // Random settings written and read back
        // ****************************************
        for (int n = 0; n < 8; n++) begin
            logic [7:0] sb;
            logic [7:0] v;
            sb = 8'($unsigned($random(seed)) % 16 + 1);
            v  = 8'($random(seed));
            acc(1'b1, (n % 2) ? IDX_RESTART : IDX_FILTER, sb, v);
            acc(1'b0, (n % 2) ? IDX_RESTART : IDX_FILTER, sb, 8'h00);
        end
        end_of_test;
    end
endmodule : tb_port_channel_input_latch_filter
